// file: dv/srs_pin_model.sv
// External reset line with pull-up, device drive and a push-button party.
`timescale 1ns/10ps
module srs_pin_model (
    input  wire logic aclk,
    input  wire logic drive_oe_n,
    output logic      pin_level
);
    logic pressed = 1'b0;
    ////////////////////////////////////////
    // Holds the line low for the given number of cycles.
    task automatic press(input int cycles);
        @(posedge aclk);
        pressed <= 1'b1;
        repeat (cycles) @(posedge aclk);
        pressed <= 1'b0;
        #1;
    endtask : press
    assign pin_level = ~(pressed | ~drive_oe_n);
endmodule : srs_pin_model

// file: dv/srs_properties.sv
// Port-level assertions for the reset and clock sequencer.
`timescale 1ns/10ps
module srs_properties (
    input wire logic                 aclk,
    input wire logic                 aresetn,
    input wire srs_pkg::srs_events_t ev,
    input wire srs_pkg::srs_ctrl_t   ctrl,
    input wire logic [11:0]          timing_count
);
    import srs_pkg::*;
    logic [12:0] low_r;
    logic [12:0] low_nxt;
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////
    // Counts the cycles of active pin drive.
    always_comb begin
        low_nxt = ctrl.rst_pin_oe_n ? 13'h0000 : low_r + 13'h0001;
    end
    always_ff @(posedge aclk) begin
        low_r <= aresetn ? low_nxt : 13'h0000;
    end
    sequence drive_start;
        !ctrl.rst_pin_oe_n && ctrl.internal_reset && timing_count == 12'h000;
    endsequence
    sequence hold_tail;
        ctrl.internal_reset throughout (##31 1'b1);
    endsequence
    ////////////////////////////////////////
    AST_DRIVE_LEN: assert property ($rose(ctrl.rst_pin_oe_n) |->
        low_r == 13'h0020 || low_r == 13'h1020) else $error("Pin drive length wrong.");
    AST_HOLD_TAIL: assert property ($rose(ctrl.rst_pin_oe_n) |->
        hold_tail ##1 !ctrl.internal_reset) else $error("Internal reset tail wrong.");
    AST_WDOG_START: assert property (ev.watchdog_overflow && !ctrl.internal_reset
        |=> drive_start) else $error("Watchdog reset start wrong.");
    AST_SRC_START: assert property ((ev.bad_opcode || ev.opcode_fetch_unmapped
        || ev.monitor_entry_reset) && !ctrl.internal_reset |=> drive_start)
        else $error("Internal reset start wrong.");
    AST_LOWV_START: assert property (ev.low_voltage_inhibit |=> drive_start)
        else $error("Low voltage reset start wrong.");
    AST_RESET_NOCLK: assert property (ctrl.internal_reset |->
        !ctrl.cpu_clk_en && ctrl.periph_clk_en == 2'h0) else $error("Clock during reset.");
    AST_BUS_DIV: assert property (ctrl.cpu_clk_en |=> !ctrl.cpu_clk_en [*3])
        else $error("Bus clock faster than a quarter.");
    AST_PERIPH_PAIR: assert property (ctrl.cpu_clk_en |-> ctrl.periph_clk_en[0])
        else $error("Peripheral clock missing.");
    AST_COUNT_RUN: assert property (ctrl.cpu_clk_en && ev[12:1] == 12'h000 |=>
        timing_count == 12'($past(timing_count) + 12'h001)) else $error("Counter stalled.");
    AST_WDOG_DIS: assert property (ctrl.watchdog_disable |->
        $past(ev.test_high_voltage_rst || ev.test_high_voltage_irq))
        else $error("Watchdog disabled without test voltage.");
endmodule : srs_properties

// file: dv/system_reset_clock_sequencer_bench.sv
// Self-checking bench of the reset and clock sequencer with a reference model.
`timescale 1ns/10ps
module system_reset_clock_sequencer_bench;
    import srs_pkg::*;
    logic        aclk, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        rst_pin_in, pll_tick = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000, timing_count, c0;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
    logic [12:0] ev_bits = 13'h0000;
    logic [7:0]  cause_m;
    srs_events_t ev;
    srs_ctrl_t   ctrl;
    int          errors = 0, cmp_count = 0, cyc = 0, n, t0, pll_p = 0, pll_ph = 0;
    logic [12:0] src_ev [6] = '{13'h0400, 13'h0200, 13'h0100, 13'h0040, 13'h0020, 13'h0800};
    logic [7:0]  src_fl [6] = '{8'h20, 8'h10, 8'h10, 8'h08, 8'h04, 8'h02};
    assign ev = srs_events_t'(ev_bits | {12'h000, pll_tick});
    srs_sequencer srs_sequencer_inst (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .ev, .rst_pin_in, .ctrl, .timing_count
    );
    srs_pin_model srs_pin_model_inst (.aclk, .drive_oe_n(ctrl.rst_pin_oe_n), .pin_level(rst_pin_in));
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    ////////////////////////////////////////
    task automatic report_and_stop;
        if (errors == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : report_and_stop
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic axi_write(input logic [11:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        check("bresp", s_axi_bresp, SRS_RESP_OKAY);
        s_axi_bready <= 1'b0;
    endtask : axi_write
    task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : axi_read
    // Reads the cause register and clears the model, as a read does.
    task automatic chk_cause;
        axi_read(SRS_ADDR_CAUSE, rd, rsp);
        check("cause", rd, {24'h0, cause_m});
        cause_m = 8'h00;
    endtask : chk_cause
    task automatic pulse(input logic [12:0] v);
        @(posedge aclk);
        ev_bits <= v;
        @(posedge aclk);
        ev_bits <= 13'h0000;
        #1;
    endtask : pulse
    task automatic wait_run(output int k);
        k = 0;
        do begin
            @(posedge aclk);
            #1;
            k++;
        end while (ctrl.internal_reset !== 1'b0);
    endtask : wait_run
    task automatic wait_cpu(output int k);
        k = 0;
        do begin
            @(posedge aclk);
            #1;
            k++;
        end while (ctrl.cpu_clk_en !== 1'b1);
    endtask : wait_cpu
    task automatic halt_wake(input int rec);
        pulse(13'h0100);
        check("halt_cnt", timing_count, 12'h000);
        pulse(13'h0010);
        wait_cpu(n);
        check("halt_rec", n >= rec && n <= rec + 5, 1'b1);
    endtask : halt_wake
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        pll_ph <= (pll_ph + 1 >= pll_p) ? 0 : pll_ph + 1;
        pll_tick <= (pll_p != 0) && (pll_ph == 0);
        if (cyc > 32'h0000_9C40) begin
            errors++;
            report_and_stop();
        end
    end
    ////////////////////////////////////////
    initial begin
        void'($urandom(72367));
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        cause_m = 8'h80;
        wait_run(n);
        check("por_len", n, SRS_POR_CYC + SRS_DRIVE_CYC + SRS_HOLD_CYC);
        chk_cause();
        axi_read(SRS_ADDR_CONFIG, rd, rsp);
        check("cfg_rst", rd, {28'h0, SRS_CFG_RESET});
        axi_read(12'h00C, rd, rsp);
        check("bad_resp", rsp, SRS_RESP_SLVERR);
        check("bad_data", rd, 32'h0);
        axi_read(SRS_ADDR_STATE, rd, rsp);
        check("state", rd[19:12], SRS_ST_RUN);
        axi_write(SRS_ADDR_CONFIG, 32'h0000_0003);
        halt_wake(SRS_SHORT_REC);
        axi_write(SRS_ADDR_CONFIG, 32'h0000_0002);
        halt_wake(SRS_LONG_REC);
        pulse(13'h0080);
        n = 0;
        t0 = 0;
        repeat (16) begin
            @(posedge aclk);
            #1;
            n += ctrl.cpu_clk_en;
            t0 += ctrl.periph_clk_en[1];
        end
        check("wait_cpu", n, 32'h0);
        check("wait_periph", t0, 32'h4);
        pulse(13'h0010);
        axi_write(SRS_ADDR_CONFIG, 32'h0000_0008);
        repeat (3) begin
            pll_p = 2 + $urandom_range(3);
            wait_cpu(n);
            wait_cpu(n);
            wait_cpu(n);
            check("pll_div", n, 4 * pll_p);
        end
        axi_write(SRS_ADDR_CONFIG, 32'h0000_0000);
        pll_p = 0;
        pulse(13'h0004);
        check("wd_off0", ctrl.watchdog_disable, 1'b0);
        pulse(13'h000C);
        check("wd_brk1", ctrl.watchdog_disable, 1'b1);
        pulse(13'h000A);
        check("wd_brk0", ctrl.watchdog_disable, 1'b0);
        axi_write(SRS_ADDR_CONFIG, 32'h0000_0004);
        pulse(13'h0004);
        check("wd_off1", ctrl.watchdog_disable, 1'b1);
        check("alt_vec", ctrl.alt_vector, 1'b1);
        pulse(13'h0002);
        check("wd_irq", ctrl.watchdog_disable, 1'b1);
        for (int i = 0; i < 6; i++) begin
            pulse(src_ev[i]);
            check("pin_drv", {ctrl.rst_pin_out, ctrl.rst_pin_oe_n}, 2'h0);
            cause_m |= src_fl[i];
            wait_run(n);
            check("src_len", n, (i == 5) ? SRS_POR_CYC + 64 : 64);
            check("src_cnt", timing_count, 12'h040);
            chk_cause();
            axi_read(SRS_ADDR_CONFIG, rd, rsp);
            check("cfg_clr", rd, 32'h0);
        end
        c0 = timing_count;
        t0 = cyc;
        srs_pin_model_inst.press(80);
        wait_run(n);
        check("ext_cnt", timing_count, 12'(c0 + 12'(cyc - t0)));
        cause_m = 8'h40;
        chk_cause();
        srs_pin_model_inst.press(20);
        wait_run(n);
        chk_cause();
        report_and_stop();
    end
endmodule : system_reset_clock_sequencer_bench
bind srs_sequencer srs_properties srs_properties_inst (.aclk, .aresetn, .ev, .ctrl, .timing_count);

// file: rtl/srs_pkg.sv
// Package with constants, types and register map of the reset and clock sequencer.
package srs_pkg;
    localparam logic [11:0] SRS_ADDR_CONFIG = 12'h000;
    localparam logic [11:0] SRS_ADDR_CAUSE  = 12'h004;
    localparam logic [11:0] SRS_ADDR_STATE  = 12'h008;
    localparam int          SRS_CFG_SHORT   = 0;
    localparam int          SRS_CFG_STOPEN  = 1;
    localparam int          SRS_CFG_MONITOR = 2;
    localparam int          SRS_CFG_PLLSEL  = 3;
    localparam logic [3:0]  SRS_CFG_RESET   = 4'h0;
    localparam logic [1:0]  SRS_RESP_OKAY   = 2'h0;
    localparam logic [1:0]  SRS_RESP_SLVERR = 2'h2;
    localparam int          SRS_CLK_MHZ     = 200;
    localparam int          SRS_REF_PERIOD_NS = 5;
    localparam int          SRS_POR_CYC     = 4096;
    localparam int          SRS_LONG_REC    = 4096;
    localparam int          SRS_SHORT_REC   = 32;
    localparam int          SRS_DRIVE_CYC   = 32;
    localparam int          SRS_HOLD_CYC    = 32;
    localparam int          SRS_EXT_MIN_CYC = 67;
    localparam logic [11:0] SRS_POR_LAST    = 12'(SRS_POR_CYC - 1);
    localparam logic [11:0] SRS_LONG_LAST   = 12'(SRS_LONG_REC - 1);
    localparam logic [11:0] SRS_SHORT_LAST  = 12'(SRS_SHORT_REC - 1);
    localparam logic [5:0]  SRS_DRIVE_LAST  = 6'(SRS_DRIVE_CYC - 1);
    localparam logic [5:0]  SRS_HOLD_LAST   = 6'(SRS_HOLD_CYC - 1);
    localparam logic [6:0]  SRS_EXT_MIN     = 7'(SRS_EXT_MIN_CYC);
    localparam logic [1:0]  SRS_DIV_LAST    = 2'h3;
    localparam logic [1:0]  SRS_DIV_HALF    = 2'h1;

    typedef enum logic [7:0] {
        SRS_ST_POR    = 8'h01,
        SRS_ST_DRIVE  = 8'h02,
        SRS_ST_HOLD   = 8'h04,
        SRS_ST_EXT    = 8'h08,
        SRS_ST_RUN    = 8'h10,
        SRS_ST_WAIT   = 8'h20,
        SRS_ST_HALT   = 8'h40,
        SRS_ST_RECOV  = 8'h80
    } srs_state_t;

    typedef struct packed {
        logic power_on;
        logic pin;
        logic watchdog_timeout;
        logic bad_opcode_flag;
        logic bad_address_flag;
        logic monitor_entry_reset;
        logic low_voltage_inhibit;
    } srs_cause_t;

    localparam srs_cause_t SRS_CAUSE_POR = 7'h40;

    typedef struct packed {
        logic power_on_pulse;
        logic low_voltage_inhibit;
        logic watchdog_overflow;
        logic bad_opcode;
        logic halt_insn;
        logic wait_insn;
        logic opcode_fetch_unmapped;
        logic monitor_entry_reset;
        logic wake_request;
        logic break_state;
        logic test_high_voltage_rst;
        logic test_high_voltage_irq;
        logic pll_out_tick;
    } srs_events_t;

    typedef struct packed {
        logic       internal_reset;
        logic       alt_vector;
        logic       cpu_clk_en;
        logic [1:0] periph_clk_en;
        logic       watchdog_disable;
        logic       rst_pin_out;
        logic       rst_pin_oe_n;
    } srs_ctrl_t;
endpackage : srs_pkg

// file: rtl/srs_sequencer.sv
// Reset sequencer, bus clock enables and timing counter with an AXI4-Lite register slave.
`timescale 1ns/10ps
// What this block does
// - Bus clock enable is the oscillator or PLL tick stream divided by four.
// - After power-on or low voltage, clocks stay off for 4096 cycles, pin low.
// - Leaving halt, counter runs on reference clock; clocks off for 4096 or 32.
// - In wait the CPU clock stops while two peripheral clock enables keep running.
// - Every reset asserts internal reset and selects normal or monitor vector pair.
// - Internal reset returns registers and modules to their default state.
// - Internal resets clear the 12-bit counter; an external reset leaves it.
// - Each reset source sets its own flag in the reset cause register.
// - External low of at least 67 cycles sets the pin flag unless power-on.
// - Internal sources drive the pin low 32 cycles, then 32 more internal reset.
// - Power-on and low voltage drive the pin low 4096+32, then 32 more.
// - Recovery totals 4160 cycles for long resets and 64 for the other internal resets.
// - Power-on sets the power-on flag and clears all other cause flags.
// - Watchdog overflow causes an internal reset and sets the watchdog flag.
// - Watchdog disable is decoded only from test voltage in monitor or break.
// - Illegal opcode resets and flags; halt with halting disabled is illegal.
// - Opcode fetch from unmapped space resets and flags; data accesses do not.
// - Low voltage sets its flag and runs the long reset sequence.
// - Monitor entry with erased vectors causes an internal reset driving the pin.
// - A 12-bit counter times oscillator startup, halt recovery and watchdog prescale.
// - Halt clears the counter; short recovery bit selects 32 instead of 4096.
// - After every reset state the counter keeps counting freely.
module srs_sequencer (
    input  wire  logic                 aclk,
    input  wire  logic                 aresetn,
    input  wire  logic [11:0]          s_axi_awaddr,
    input  wire  logic                 s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire  logic [31:0]          s_axi_wdata,
    input  wire  logic [3:0]           s_axi_wstrb,
    input  wire  logic                 s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire  logic                 s_axi_bready,
    input  wire  logic [11:0]          s_axi_araddr,
    input  wire  logic                 s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire  logic                 s_axi_rready,
    input  wire  srs_pkg::srs_events_t ev,
    input  wire  logic                 rst_pin_in,
    output srs_pkg::srs_ctrl_t         ctrl,
    output logic [11:0]                timing_count
);
    import srs_pkg::*;

    typedef struct packed {
        srs_state_t  state;
        logic [11:0] cnt;
        logic [5:0]  sub;
        logic [6:0]  low_cnt;
        logic [1:0]  div;
        logic [1:0]  pin_sync;
        srs_cause_t  cause;
        logic [3:0]  cfg;
        logic        aw_got;
        logic        w_got;
        logic [11:0] aw_addr;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        srs_ctrl_t   ctrl;
    } srs_regs_t;

    srs_regs_t r;
    srs_regs_t n;

    function automatic logic in_reset(input srs_state_t s);
        in_reset = (s == SRS_ST_POR) || (s == SRS_ST_DRIVE) ||
                   (s == SRS_ST_HOLD) || (s == SRS_ST_EXT);
    endfunction : in_reset

    function automatic logic is_mapped(input logic [11:0] a);
        is_mapped = (a == SRS_ADDR_CONFIG) || (a == SRS_ADDR_CAUSE) ||
                    (a == SRS_ADDR_STATE);
    endfunction : is_mapped

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic       src_tick;
        logic       bus_tick;
        logic       half_tick;
        logic       long_req;
        logic       short_req;
        logic       halt_bad;
        logic       pin_low;
        logic       rd_cause;
        logic       do_wr;
        srs_cause_t set;
        src_tick  = 1'b0;
        bus_tick  = 1'b0;
        half_tick = 1'b0;
        long_req  = 1'b0;
        short_req = 1'b0;
        halt_bad  = 1'b0;
        pin_low   = 1'b0;
        rd_cause  = 1'b0;
        do_wr     = 1'b0;
        set       = '0;
        n         = r;

        // The pin is sampled through two flip-flops before any use.
        n.pin_sync = {r.pin_sync[0], rst_pin_in};
        pin_low    = !r.pin_sync[1];

        // Bus clock rate is the selected source divided by four.
        src_tick  = r.cfg[SRS_CFG_PLLSEL] ? ev.pll_out_tick : 1'b1;
        if (src_tick) begin
            n.div = r.div + 2'h1;
        end
        bus_tick  = src_tick && (r.div == SRS_DIV_LAST);
        half_tick = src_tick && (r.div == SRS_DIV_HALF);

        // The timing counter runs freely unless a sequence clears or holds it.
        n.cnt = r.cnt + 12'h001;

        halt_bad  = ev.halt_insn && !r.cfg[SRS_CFG_STOPEN];
        long_req  = ev.power_on_pulse || ev.low_voltage_inhibit;
        short_req = ev.watchdog_overflow || ev.bad_opcode || halt_bad ||
                    ev.opcode_fetch_unmapped || ev.monitor_entry_reset;

        set.power_on            = ev.power_on_pulse;
        set.low_voltage_inhibit = ev.low_voltage_inhibit;
        set.watchdog_timeout    = ev.watchdog_overflow;
        set.bad_opcode_flag     = ev.bad_opcode || halt_bad;
        set.bad_address_flag    = ev.opcode_fetch_unmapped;
        set.monitor_entry_reset = ev.monitor_entry_reset;

        case (r.state)
            SRS_ST_POR: begin
                if (r.cnt == SRS_POR_LAST) begin
                    n.state = SRS_ST_DRIVE;
                    n.sub   = '0;
                end
            end
            SRS_ST_DRIVE: begin
                n.sub = r.sub + 6'h01;
                if (r.sub == SRS_DRIVE_LAST) begin
                    n.state = SRS_ST_HOLD;
                    n.sub   = '0;
                end
            end
            SRS_ST_HOLD: begin
                n.sub = r.sub + 6'h01;
                if (r.sub == SRS_HOLD_LAST) begin
                    n.state = SRS_ST_RUN;
                end
            end
            SRS_ST_EXT: begin
                if (r.low_cnt != SRS_EXT_MIN) begin
                    n.low_cnt = r.low_cnt + 7'h01;
                end
                if (!pin_low) begin
                    set.pin = (r.low_cnt >= SRS_EXT_MIN);
                    n.state = SRS_ST_HOLD;
                    n.sub   = '0;
                end
            end
            SRS_ST_RUN: begin
                if (ev.wait_insn) begin
                    n.state = SRS_ST_WAIT;
                end else if (ev.halt_insn && r.cfg[SRS_CFG_STOPEN]) begin
                    n.state = SRS_ST_HALT;
                    n.cnt   = '0;
                end
            end
            SRS_ST_WAIT: begin
                if (ev.wake_request) begin
                    n.state = SRS_ST_RUN;
                end
            end
            SRS_ST_HALT: begin
                n.cnt = '0;
                if (ev.wake_request) begin
                    n.state = SRS_ST_RECOV;
                end
            end
            SRS_ST_RECOV: begin
                if (r.cfg[SRS_CFG_SHORT] ? (r.cnt == SRS_SHORT_LAST)
                                         : (r.cnt == SRS_LONG_LAST)) begin
                    n.state = SRS_ST_RUN;
                end
            end
            default: begin
                n.state = SRS_ST_POR;
                n.cnt   = '0;
            end
        endcase

        // An external low outside a reset sequence leaves the counter running.
        if (!in_reset(r.state) && pin_low) begin
            n.state   = SRS_ST_EXT;
            n.low_cnt = 7'h01;
        end
        if (!in_reset(r.state) && short_req) begin
            n.state = SRS_ST_DRIVE;
            n.sub   = '0;
            n.cnt   = '0;
        end
        if (long_req) begin
            n.state = SRS_ST_POR;
            n.cnt   = '0;
        end

        ////////////////////////////////////////////////////////////////////////////////
        // Write channel: address and data are taken in either order.
        if (s_axi_awvalid && r.ctrl.rst_pin_oe_n && !r.aw_got && !r.bvalid) begin
            n.aw_got  = 1'b1;
            n.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !r.w_got && !r.bvalid) begin
            n.w_got  = 1'b1;
            n.w_data = s_axi_wdata;
            n.w_strb = s_axi_wstrb;
        end
        if (r.aw_got && r.w_got) begin
            do_wr    = 1'b1;
            n.aw_got = 1'b0;
            n.w_got  = 1'b0;
            n.bvalid = 1'b1;
            n.bresp  = is_mapped(r.aw_addr) ? SRS_RESP_OKAY : SRS_RESP_SLVERR;
        end
        if (r.bvalid && s_axi_bready) begin
            n.bvalid = 1'b0;
        end
        if (do_wr && (r.aw_addr == SRS_ADDR_CONFIG) && r.w_strb[0]) begin
            n.cfg = r.w_data[3:0];
        end
        // The internal reset returns the configuration to its default.
        if (in_reset(r.state)) begin
            n.cfg = SRS_CFG_RESET;
        end

        // Read channel: reading the cause register clears flags not newly set.
        if (s_axi_arvalid && !r.rvalid) begin
            n.rvalid = 1'b1;
            n.rresp  = is_mapped(s_axi_araddr) ? SRS_RESP_OKAY : SRS_RESP_SLVERR;
            case (s_axi_araddr)
                SRS_ADDR_CONFIG: n.rdata = {28'h0000000, r.cfg};
                SRS_ADDR_CAUSE: begin
                    n.rdata  = {24'h000000, r.cause, 1'b0};
                    rd_cause = 1'b1;
                end
                SRS_ADDR_STATE:  n.rdata = {12'h000, r.state, r.cnt};
                default:         n.rdata = 32'h00000000;
            endcase
        end
        if (r.rvalid && s_axi_rready) begin
            n.rvalid = 1'b0;
        end
        n.cause = (rd_cause ? srs_cause_t'('0) : r.cause) | set;
        if (ev.power_on_pulse) begin
            n.cause = SRS_CAUSE_POR;
        end

        ////////////////////////////////////////////////////////////////////////////////
        // Outputs are registered; reset, clock enables and pin drive come from the next state.
        n.ctrl.internal_reset = in_reset(n.state);
        n.ctrl.alt_vector     = r.cfg[SRS_CFG_MONITOR];
        n.ctrl.cpu_clk_en     = bus_tick && (n.state == SRS_ST_RUN);
        n.ctrl.periph_clk_en  = {half_tick, bus_tick} &
                                {2{(n.state == SRS_ST_RUN) || (n.state == SRS_ST_WAIT)}};
        n.ctrl.watchdog_disable =
            (r.cfg[SRS_CFG_MONITOR] && (ev.test_high_voltage_rst || ev.test_high_voltage_irq))
            || (ev.break_state && ev.test_high_voltage_rst);
        n.ctrl.rst_pin_out    = 1'b0;
        n.ctrl.rst_pin_oe_n   = !((n.state == SRS_ST_POR) || (n.state == SRS_ST_DRIVE));
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r              <= '0;
            r.state        <= SRS_ST_POR;
            r.cause        <= SRS_CAUSE_POR;
            r.cfg          <= SRS_CFG_RESET;
            r.pin_sync     <= 2'h3;
            r.ctrl.internal_reset <= 1'b1;
            r.ctrl.rst_pin_oe_n   <= 1'b0;
        end else begin
            r <= n;
        end
    end

    assign s_axi_awready = s_axi_awvalid && r.ctrl.rst_pin_oe_n && !r.aw_got && !r.bvalid;
    assign s_axi_wready  = s_axi_wvalid && !r.w_got && !r.bvalid;
    assign s_axi_bvalid  = r.bvalid;
    assign s_axi_bresp   = r.bresp;
    assign s_axi_arready = s_axi_arvalid && !r.rvalid;
    assign s_axi_rvalid  = r.rvalid;
    assign s_axi_rdata   = r.rdata;
    assign s_axi_rresp   = r.rresp;
    assign ctrl          = r.ctrl;
    assign timing_count  = r.cnt;
endmodule : srs_sequencer
